// ==== src/tw_cfg.svh ====
// register map, field positions, reset values and fixed counts of the waveform timer
`ifndef TW_CFG_SVH
`define TW_CFG_SVH

// apb byte offsets
`define TW_OFF_CTRL_A 8'h00
`define TW_OFF_CTRL_B 8'h04
`define TW_OFF_COUNT 8'h08
`define TW_OFF_CMP_A 8'h0C
`define TW_OFF_CMP_B 8'h10
`define TW_OFF_CMP_C 8'h14
`define TW_OFF_CAPT 8'h18
`define TW_OFF_STATUS 8'h1C
`define TW_OFF_PIN_DIR 8'h20

// field positions
`define TW_F_COM_A 7:6
`define TW_F_COM_B 5:4
`define TW_F_COM_C 3:2
`define TW_F_WGM_LO 1:0
`define TW_F_WGM_HI 4:3
`define TW_F_CSEL 2:0
`define TW_F_OVF 0
`define TW_F_DOWN 1

// reset values
`define TW_RST_CTRL_A 8'h00
`define TW_RST_CTRL_B 5'h00
`define TW_RST_WORD 16'h0000
`define TW_RST_PIN_DIR 3'h0

// fixed top values
`define TW_TOP_8 16'h00FF
`define TW_TOP_9 16'h01FF
`define TW_TOP_10 16'h03FF
`define TW_MAX 16'hFFFF
`define TW_BOTTOM 16'h0000

// waveform mode codes
`define TW_WGM_NORMAL 4'h0
`define TW_WGM_CTC_A 4'h4
`define TW_WGM_CTC_CAPT 4'hC
`define TW_WGM_RSVD 4'hD

// clock select codes
`define TW_CS_DIV1 3'h1
`define TW_CS_DIV8 3'h2
`define TW_CS_DIV64 3'h3
`define TW_CS_DIV256 3'h4
`define TW_CS_DIV1024 3'h5

`endif

// ==== src/tw_chan.sv ====
// one compare channel: buffered compare value and compare output flip-flop
`timescale 1ns/1ns
module tw_chan
   import tw_pkg::*;
#(
   parameter bit IS_CHAN_A = 1'b0
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic [3:0] wgm,
   input wire logic [1:0] out_mode,
   input wire logic [15:0] cnt,
   input wire logic [15:0] top,
   input wire logic dir_up,
   input wire logic reload,
   input wire logic wr_en,
   input wire logic [15:0] wr_data,
   output logic [15:0] buf_q,
   output logic [15:0] act_q,
   output logic out_q
);

   // ==========================================================
   // match decode
   tw_kind_e kind;
   logic match;
   logic at_top;
   logic toggle_ok;
   logic top_ignore;

   assign kind = tw_kind(wgm);
   assign match = tick && (cnt == act_q);
   assign at_top = tick && (cnt == top);
   // channel a alone may toggle in pwm families
   assign toggle_ok = (kind == TW_K_NONPWM) ||
      (IS_CHAN_A && (kind == TW_K_FAST) && (wgm[3:1] == 3'h7)) ||
      (IS_CHAN_A && (kind != TW_K_FAST) && (wgm[3:2] == 2'h2));
   assign top_ignore = out_mode[1] && (act_q == top);

   // ==========================================================
   // compare value buffer and active copy
   always_ff @(posedge core_clk) begin
      if (rst) begin
         buf_q <= `TW_RST_WORD;
      end else if (wr_en) begin
         buf_q <= wr_data;
      end
   end

   // immediate in non-pwm modes, else loaded on the reload event
   always_ff @(posedge core_clk) begin
      if (rst) begin
         act_q <= `TW_RST_WORD;
      end else if (kind == TW_K_NONPWM) begin
         act_q <= wr_en ? wr_data : buf_q;
      end else if (reload) begin
         act_q <= buf_q;
      end
   end

   // ==========================================================
   // compare output action
   always_ff @(posedge core_clk) begin
      if (rst) begin
         out_q <= 1'b0;
      end else if (tick && (out_mode != 2'h0)) begin
         unique case (kind)
            TW_K_NONPWM: begin
               if (match) begin
                  out_q <= (out_mode == 2'h1) ? ~out_q : out_mode[0];
               end
            end
            TW_K_FAST: begin
               if (out_mode == 2'h1) begin
                  if (match && toggle_ok) begin
                     out_q <= ~out_q;
                  end
               end else if (at_top) begin
                  out_q <= ~out_mode[0];
               end else if (match && !top_ignore) begin
                  out_q <= out_mode[0];
               end
            end
            TW_K_PC, TW_K_PFC: begin
               if (match) begin
                  if (out_mode == 2'h1) begin
                     out_q <= toggle_ok ? ~out_q : out_q;
                  end else begin
                     out_q <= dir_up ? out_mode[0] : ~out_mode[0];
                  end
               end
            end
            TW_K_RSVD: begin
               out_q <= out_q;
            end
            default: begin
               out_q <= out_q;
            end
         endcase
      end
   end

endmodule

// ==== src/tw_pkg.sv ====
// types and mode decoding shared by the waveform timer files
`include "tw_cfg.svh"
package tw_pkg;

   // waveform family selected by the mode field
   typedef enum logic [2:0] {
      TW_K_NONPWM = 3'h0,
      TW_K_FAST = 3'h1,
      TW_K_PFC = 3'h2,
      TW_K_PC = 3'h3,
      TW_K_RSVD = 3'h6
   } tw_kind_e;

   // count direction state
   typedef enum logic {
      TW_UP = 1'h0,
      TW_DOWN = 1'h1
   } tw_dir_e;

   // map a mode code onto its waveform family
   function automatic tw_kind_e tw_kind(input logic [3:0] wgm);
      tw_kind_e k;
      k = TW_K_NONPWM;
      unique case (wgm)
         4'h1, 4'h2, 4'h3, 4'hA, 4'hB: k = TW_K_PC;
         4'h5, 4'h6, 4'h7, 4'hE, 4'hF: k = TW_K_FAST;
         4'h8, 4'h9: k = TW_K_PFC;
         `TW_WGM_RSVD: k = TW_K_RSVD;
         4'h0, 4'h4, 4'hC: k = TW_K_NONPWM;
      endcase
      return k;
   endfunction

endpackage

// ==== src/tw_timer.sv ====
// 16-bit timer waveform mode decode, counter and three compare outputs behind apb
`timescale 1ns/1ns

// Overview of operation
// - frequency-correct mode reloads compares at bottom
// - nonzero output mode overrides the pin
// - pin driven only when direction is output
// - output mode zero leaves pin disconnected
// - non-pwm: toggle, clear or set on match
// - fast pwm: match and top act opposite
// - fast pwm toggle only channel a, modes 14-15
// - fast pwm: compare equal top ignores match except in toggle mode
// - dual slope: action flips with count direction
// - dual slope toggle only channel a, modes 8-11
// - mode is four bits over two controls
// - mode 0: top max, immediate, flag at max
// - modes 1-3: fixed top phase-correct pwm
// - fast modes reload and flag at top
// - clear-on-match modes 4 and 12
// - modes 8-9 frequency correct, flag at bottom
// - modes 10-11 phase correct; 13 reserved
// - dual slope turns at top with no hold tick
// - counter advances only on timer tick
module tw_timer
   import tw_pkg::*;
#(
   parameter int PRE_W = 10
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic compare_out_a,
   output logic compare_out_b,
   output logic compare_out_c,
   output logic compare_oe_a,
   output logic compare_oe_b,
   output logic compare_oe_c,
   output logic pin_override_a,
   output logic pin_override_b,
   output logic pin_override_c,
   output logic overflow_flag
);

   // prescaler must reach the slowest divider
   if (PRE_W < 10) begin : g_bad_pre
      $error("tw_timer: PRE_W below 10 cannot divide by 1024");
   end

   // ==========================================================
   // registers and bus state
   logic [7:0] ctrl_a_q;
   logic [4:0] ctrl_b_q;
   logic [15:0] capt_q;
   logic [2:0] pin_dir_q;
   logic ovf_q;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [PRE_W-1:0] pre_q;
   logic tick_q;
   logic [15:0] cnt_q;
   tw_dir_e dir_q;
   logic [2:0] oe_q;
   logic [2:0] ovr_q;

   logic acc;
   logic wr;
   logic mapped;
   logic [31:0] rd_mux;
   logic [3:0] wgm;
   tw_kind_e kind;
   logic [15:0] top;
   logic [15:0] buf_a, buf_b, buf_c;
   logic [15:0] act_a, act_b, act_c;
   logic cnt_wr;
   logic tov_evt;
   logic reload;
   logic at_top;
   logic at_bottom;

   // ==========================================================
   // apb slave: one wait state, then pready for a single cycle
   assign acc = psel && penable && pready_q;
   assign wr = acc && pwrite;
   assign cnt_wr = wr && (paddr == `TW_OFF_COUNT);

   // read mux and address decode
   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h00000000;
      unique case (paddr)
         `TW_OFF_CTRL_A: rd_mux[7:0] = ctrl_a_q;
         `TW_OFF_CTRL_B: rd_mux[4:0] = ctrl_b_q;
         `TW_OFF_COUNT: rd_mux[15:0] = cnt_q;
         `TW_OFF_CMP_A: rd_mux[15:0] = buf_a;
         `TW_OFF_CMP_B: rd_mux[15:0] = buf_b;
         `TW_OFF_CMP_C: rd_mux[15:0] = buf_c;
         `TW_OFF_CAPT: rd_mux[15:0] = capt_q;
         `TW_OFF_STATUS: begin
            rd_mux[`TW_F_OVF] = ovf_q;
            rd_mux[`TW_F_DOWN] = (dir_q == TW_DOWN);
         end
         `TW_OFF_PIN_DIR: rd_mux[2:0] = pin_dir_q;
         default: mapped = 1'b0;
      endcase
   end

   // answer handshake
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel && penable && !pready_q;
         if (psel && penable && !pready_q) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_q <= !mapped;
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   // control, capture and pin direction registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_a_q <= `TW_RST_CTRL_A;
         ctrl_b_q <= `TW_RST_CTRL_B;
         capt_q <= `TW_RST_WORD;
         pin_dir_q <= `TW_RST_PIN_DIR;
      end else if (wr) begin
         if (paddr == `TW_OFF_CTRL_A) begin
            ctrl_a_q <= pwdata[7:0];
         end
         if (paddr == `TW_OFF_CTRL_B) begin
            ctrl_b_q <= pwdata[4:0];
         end
         if (paddr == `TW_OFF_CAPT) begin
            capt_q <= pwdata[15:0];
         end
         if (paddr == `TW_OFF_PIN_DIR) begin
            pin_dir_q <= pwdata[2:0];
         end
      end
   end

   // ==========================================================
   // prescaler: one-cycle timer tick from the selected divider
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pre_q <= '0;
      end else if (ctrl_b_q[`TW_F_CSEL] != 3'h0) begin
         pre_q <= pre_q + PRE_W'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tick_q <= 1'b0;
      end else begin
         unique case (ctrl_b_q[`TW_F_CSEL])
            `TW_CS_DIV1: tick_q <= 1'b1;
            `TW_CS_DIV8: tick_q <= &pre_q[2:0];
            `TW_CS_DIV64: tick_q <= &pre_q[5:0];
            `TW_CS_DIV256: tick_q <= &pre_q[7:0];
            `TW_CS_DIV1024: tick_q <= &pre_q[9:0];
            default: tick_q <= 1'b0;
         endcase
      end
   end

   // ==========================================================
   // mode decode and top source
   assign wgm = {ctrl_b_q[`TW_F_WGM_HI], ctrl_a_q[`TW_F_WGM_LO]};
   assign kind = tw_kind(wgm);

   always_comb begin
      unique case (wgm)
         4'h0: top = `TW_MAX;
         4'h1, 4'h5: top = `TW_TOP_8;
         4'h2, 4'h6: top = `TW_TOP_9;
         4'h3, 4'h7: top = `TW_TOP_10;
         4'h4, 4'h9, 4'hB, 4'hF: top = act_a;
         4'h8, 4'hA, 4'hC, 4'hE: top = capt_q;
         4'hD: top = `TW_BOTTOM;
      endcase
   end

   assign at_top = tick_q && (cnt_q == top);
   assign at_bottom = tick_q && (cnt_q == `TW_BOTTOM) && (dir_q == TW_DOWN);

   // reload point and overflow point per family
   always_comb begin
      reload = 1'b0;
      tov_evt = 1'b0;
      unique case (kind)
         TW_K_NONPWM: tov_evt = tick_q && (cnt_q == `TW_MAX);
         TW_K_FAST: begin
            reload = at_top;
            tov_evt = at_top;
         end
         TW_K_PC: begin
            reload = at_top;
            tov_evt = at_bottom;
         end
         TW_K_PFC: begin
            reload = at_bottom;
            tov_evt = at_bottom;
         end
         TW_K_RSVD: reload = 1'b0;
         default: reload = 1'b0;
      endcase
   end

   // ==========================================================
   // counter and direction
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_q <= `TW_BOTTOM;
         dir_q <= TW_UP;
      end else if (cnt_wr) begin
         cnt_q <= pwdata[15:0];
      end else if (tick_q) begin
         unique case (kind)
            TW_K_NONPWM: begin
               if ((wgm != `TW_WGM_NORMAL) && (cnt_q == top)) begin
                  cnt_q <= `TW_BOTTOM;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
               dir_q <= TW_UP;
            end
            TW_K_FAST: begin
               cnt_q <= (cnt_q >= top) ? `TW_BOTTOM : cnt_q + 16'h0001;
               dir_q <= TW_UP;
            end
            TW_K_PC, TW_K_PFC: begin
               unique case (dir_q)
                  TW_UP: begin
                     if (cnt_q >= top) begin
                        cnt_q <= cnt_q - 16'h0001;
                        dir_q <= TW_DOWN;
                     end else begin
                        cnt_q <= cnt_q + 16'h0001;
                     end
                  end
                  TW_DOWN: begin
                     if (cnt_q == `TW_BOTTOM) begin
                        cnt_q <= cnt_q + 16'h0001;
                        dir_q <= TW_UP;
                     end else begin
                        cnt_q <= cnt_q - 16'h0001;
                     end
                  end
               endcase
            end
            TW_K_RSVD: begin
               cnt_q <= `TW_BOTTOM;
               dir_q <= TW_UP;
            end
            default: begin
               cnt_q <= `TW_BOTTOM;
               dir_q <= TW_UP;
            end
         endcase
      end
   end

   // overflow flag: set wins over write-one-to-clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ovf_q <= 1'b0;
      end else if (tov_evt) begin
         ovf_q <= 1'b1;
      end else if (wr && (paddr == `TW_OFF_STATUS) && pwdata[`TW_F_OVF]) begin
         ovf_q <= 1'b0;
      end
   end

   // ==========================================================
   // pin override and output enable
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ovr_q <= 3'h0;
         oe_q <= 3'h0;
      end else begin
         ovr_q[0] <= |ctrl_a_q[`TW_F_COM_A];
         ovr_q[1] <= |ctrl_a_q[`TW_F_COM_B];
         ovr_q[2] <= |ctrl_a_q[`TW_F_COM_C];
         oe_q[0] <= |ctrl_a_q[`TW_F_COM_A] && pin_dir_q[0];
         oe_q[1] <= |ctrl_a_q[`TW_F_COM_B] && pin_dir_q[1];
         oe_q[2] <= |ctrl_a_q[`TW_F_COM_C] && pin_dir_q[2];
      end
   end

   // ==========================================================
   // compare channels
   tw_chan #(.IS_CHAN_A(1'b1)) u_chan_a (
      .core_clk(core_clk), .rst(rst), .tick(tick_q), .wgm(wgm),
      .out_mode(ctrl_a_q[`TW_F_COM_A]), .cnt(cnt_q), .top(top), .dir_up(dir_q == TW_UP),
      .reload(reload), .wr_en(wr && (paddr == `TW_OFF_CMP_A)), .wr_data(pwdata[15:0]),
      .buf_q(buf_a), .act_q(act_a), .out_q(compare_out_a)
   );

   tw_chan #(.IS_CHAN_A(1'b0)) u_chan_b (
      .core_clk(core_clk), .rst(rst), .tick(tick_q), .wgm(wgm),
      .out_mode(ctrl_a_q[`TW_F_COM_B]), .cnt(cnt_q), .top(top), .dir_up(dir_q == TW_UP),
      .reload(reload), .wr_en(wr && (paddr == `TW_OFF_CMP_B)), .wr_data(pwdata[15:0]),
      .buf_q(buf_b), .act_q(act_b), .out_q(compare_out_b)
   );

   tw_chan #(.IS_CHAN_A(1'b0)) u_chan_c (
      .core_clk(core_clk), .rst(rst), .tick(tick_q), .wgm(wgm),
      .out_mode(ctrl_a_q[`TW_F_COM_C]), .cnt(cnt_q), .top(top), .dir_up(dir_q == TW_UP),
      .reload(reload), .wr_en(wr && (paddr == `TW_OFF_CMP_C)), .wr_data(pwdata[15:0]),
      .buf_q(buf_c), .act_q(act_c), .out_q(compare_out_c)
   );

   // registered outputs
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pin_override_a = ovr_q[0];
   assign pin_override_b = ovr_q[1];
   assign pin_override_c = ovr_q[2];
   assign compare_oe_a = oe_q[0];
   assign compare_oe_b = oe_q[1];
   assign compare_oe_c = oe_q[2];
   assign overflow_flag = ovf_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_pfc_bottom_reload: assert property ((kind == TW_K_PFC) && at_bottom && !cnt_wr |=>
      act_b == $past(buf_b)) else $error("compare not reloaded at bottom");
   chk_pin_override: assert property ((ctrl_a_q[`TW_F_COM_B] != 2'h0) [*2] |-> pin_override_b)
      else $error("override missing for nonzero output mode");
   chk_oe_needs_dir: assert property (compare_oe_c |-> $past(pin_dir_q[2]) && pin_override_c)
      else $error("pin driven without output direction");
   chk_off_no_drive: assert property ((ctrl_a_q[`TW_F_COM_A] == 2'h0) [*2] |->
      !compare_oe_a && $stable(compare_out_a)) else $error("disconnected channel acted");
   chk_nonpwm_toggle: assert property ((kind == TW_K_NONPWM) && (ctrl_a_q[`TW_F_COM_A] == 2'h1) &&
      tick_q && (cnt_q == act_a) |=> compare_out_a != $past(compare_out_a)) else $error("no toggle on match");
   chk_fast_top_set: assert property ((kind == TW_K_FAST) && (ctrl_a_q[`TW_F_COM_B] == 2'h2) &&
      at_top |=> compare_out_b) else $error("fast pwm output not set at top");
   chk_fast_b_quiet: assert property ((kind == TW_K_FAST) && (ctrl_a_q[`TW_F_COM_B] == 2'h1) |=>
      $stable(compare_out_b)) else $error("channel b toggled in fast pwm");
   chk_dual_down_set: assert property ((kind == TW_K_PC) && (ctrl_a_q[`TW_F_COM_B] == 2'h2) && tick_q &&
      (cnt_q == act_b) && (dir_q == TW_DOWN) |=> compare_out_b) else $error("down match did not set");
   chk_tov_at_top: assert property ((kind == TW_K_FAST) && at_top |=> overflow_flag)
      else $error("overflow not raised at top");
   chk_dual_top_turn: assert property ((kind == TW_K_PFC) && at_top && (dir_q == TW_UP) &&
      (top != `TW_BOTTOM) && !cnt_wr |=> (dir_q == TW_DOWN) && (cnt_q == 16'($past(cnt_q) - 16'h0001)))
      else $error("dual slope did not turn at top");
   chk_no_tick_hold: assert property (!tick_q && !cnt_wr |=> $stable(cnt_q))
      else $error("counter moved without tick");
   chk_reserved_idle: assert property ((wgm == `TW_WGM_RSVD) && tick_q && !cnt_wr |=>
      (cnt_q == `TW_BOTTOM) && $stable(compare_out_a)) else $error("reserved mode not parked");

   cov_fast_top: cover property ((kind == TW_K_FAST) && at_top);
   cov_pfc_bottom: cover property ((kind == TW_K_PFC) && at_bottom);
   cov_ovf_clear_race: cover property (tov_evt && wr && (paddr == `TW_OFF_STATUS));
   cov_ctc_wrap: cover property ((wgm == `TW_WGM_CTC_A) && at_top);

endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the waveform timer: apb access, mode decode and compare outputs
`timescale 1ns/1ns
`include "tw_cfg.svh"
module tb_top;
   import tw_pkg::*;
   // ==========================================
   // signals, instance and clock
   logic core_clk, rst, psel, penable, pwrite, pready, pslverr, ov, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [2:0] o, oe, ovr;
   int n_errors, n_checks;
   logic [3:0] md [12] = '{4'h5, 4'h6, 4'h7, 4'hE, 4'hF, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
   logic [15:0] tp [12] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h0123, 16'h0155, 16'h00FF, 16'h01FF,
      16'h03FF, 16'h0123, 16'h0155, 16'h0123, 16'h0155};

   tw_timer i_tw_timer (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .compare_out_a(o[2]), .compare_out_b(o[1]), .compare_out_c(o[0]), .compare_oe_a(oe[2]),
      .compare_oe_b(oe[1]), .compare_oe_c(oe[0]), .pin_override_a(ovr[2]), .pin_override_b(ovr[1]),
      .pin_override_c(ovr[0]), .overflow_flag(ov));

   // free-running 100 ns clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // ==========================================
   // shared tasks and expectations
   task print_verdict;
      if (n_errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; read data and error land in q and e
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge core_clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 20) begin
         n_errors++;
         print_verdict;
      end
   endtask

   // select a mode, run the timer undivided for n cycles, then stop it
   task run(input logic [3:0] m, input logic [5:0] com, input int n);
      apb(1'b1, `TW_OFF_CTRL_A, {24'h0, com, m[1:0]});
      apb(1'b1, `TW_OFF_CTRL_B, {27'h0, m[3:2], `TW_CS_DIV1});
      repeat (n) @(posedge core_clk);
      apb(1'b1, `TW_OFF_CTRL_B, {27'h0, m[3:2], 3'h0});
      @(negedge core_clk);
   endtask

   task do_reset;
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
   endtask

   // single slope: high from bottom through the match, inverted for mode 11
   function automatic logic fast_out(input logic [15:0] c, input logic [15:0] m, input logic inv);
      return (c <= m) ^ inv;
   endfunction

   // dual slope: low above the match going up, at or above it going down
   function automatic logic dual_out(input logic [15:0] c, input logic dn, input logic [15:0] m,
      input logic inv);
      return !((!dn && c > m) || (dn && c >= m)) ^ inv;
   endfunction

   // ==========================================
   // main sequence
   initial begin
      int k, na, nb;
      logic [15:0] top, mb, mc, c;
      logic [5:0] com;
      logic [3:0] m;
      logic dr, pa, pb;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_errors = 0;
      n_checks = 0;
      q = $urandom(10826);
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      // reset values, unmapped address, buffer write and read back
      for (k = 0; k < 9; k++) begin
         apb(1'b0, 8'(4 * k), 32'h0);
         chk(q, 32'h0);
      end
      apb(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, e}, 32'h1);
      c = $urandom;
      apb(1'b1, `TW_OFF_CMP_B, {16'hFFFF, c});
      apb(1'b0, `TW_OFF_CMP_B, 32'h0);
      chk(q, {16'h0, c});
      // pin override and output enable per channel
      repeat (8) begin
         com = $urandom;
         dr = $urandom;
         apb(1'b1, `TW_OFF_PIN_DIR, {29'h0, {3{dr}}});
         apb(1'b1, `TW_OFF_CTRL_A, {24'h0, com, 2'h0});
         repeat (2) @(negedge core_clk);
         for (k = 0; k < 3; k++) begin
            chk(ovr[k], |com[2 * k +: 2]);
            chk(oe[k], |com[2 * k +: 2] & dr);
         end
      end
      // normal mode: set, clear, toggle on a match
      apb(1'b1, `TW_OFF_CMP_A, 32'h5);
      for (k = 0; k < 3; k++) begin
         apb(1'b1, `TW_OFF_COUNT, 32'h0);
         run(4'h0, {2'(3 - k), 4'h0}, 20);
         chk(o[2], k != 1);
      end
      // overflow at max, cleared by writing one
      apb(1'b1, `TW_OFF_COUNT, 32'hFFE0);
      run(4'h0, 6'h0, 5);
      chk(ov, 1'b0);
      run(4'h0, 6'h0, 40);
      apb(1'b0, `TW_OFF_STATUS, 32'h0);
      chk({ov, q[0]}, 2'b11);
      apb(1'b1, `TW_OFF_STATUS, 32'h1);
      @(negedge core_clk);
      chk(ov, 1'b0);
      // clear-on-match tops from compare a and capture
      apb(1'b1, `TW_OFF_CAPT, 32'h9);
      for (k = 0; k < 2; k++) begin
         // start below top, else the count runs on to max before wrapping
         apb(1'b1, `TW_OFF_COUNT, 32'h0);
         run(k ? `TW_WGM_CTC_CAPT : `TW_WGM_CTC_A, 6'h0, 30 + $urandom % 50);
         apb(1'b0, `TW_OFF_COUNT, 32'h0);
         chk(q <= (k ? 9 : 5), 1'b1);
      end
      // every pwm mode, then random ones, with random compare values
      for (k = 0; k < 18; k++) begin
         na = k < 12 ? k : $urandom % 12;
         m = md[na];
         top = tp[na];
         mb = na < 5 ? $urandom % (top + 1) : 1 + $urandom % (top - 1);
         mc = na < 5 ? $urandom % (top + 1) : 1 + $urandom % (top - 1);
         if (k == 0) {mb, mc} = {top, 16'h0};
         if (k == 5) {mb, mc} = {16'h1, 16'(top - 1)};
         do_reset;
         apb(1'b1, `TW_OFF_CAPT, 32'h0123);
         apb(1'b1, `TW_OFF_CMP_A, 32'h0155);
         apb(1'b1, `TW_OFF_CMP_B, {16'h0, mb});
         apb(1'b1, `TW_OFF_CMP_C, {16'h0, mc});
         run(m, 6'b00_10_11, 4 * top + 100 + $urandom % 1000);
         apb(1'b0, `TW_OFF_COUNT, 32'h0);
         c = q[15:0];
         apb(1'b0, `TW_OFF_STATUS, 32'h0);
         chk(c <= top, 1'b1);
         chk(ov, 1'b1);
         if (na < 5)
            chk(o[1:0], {fast_out(c, mb, 0), fast_out(c, mc, 1)});
         else
            chk(o[1:0], {dual_out(c, q[1], mb, 0), dual_out(c, q[1], mc, 1)});
      end
      // toggle mode allowed only on channel a in modes 14, 15 and 8 to 11
      for (k = 0; k < 4; k++) begin
         m = k[1] ? (k[0] ? 4'h2 : 4'h5) : (k[0] ? 4'hA : 4'hE);
         do_reset;
         apb(1'b1, `TW_OFF_CAPT, 32'h40);
         apb(1'b1, `TW_OFF_CMP_A, 32'h20);
         apb(1'b1, `TW_OFF_CMP_B, 32'h20);
         apb(1'b1, `TW_OFF_CTRL_A, {24'h0, 6'b01_01_00, m[1:0]});
         apb(1'b1, `TW_OFF_CTRL_B, {27'h0, m[3:2], `TW_CS_DIV1});
         {na, nb, pa, pb} = {32'h0, 32'h0, o[2], o[1]};
         repeat (1200) begin
            @(negedge core_clk);
            na += (o[2] !== pa);
            nb += (o[1] !== pb);
            {pa, pb} = o[2:1];
         end
         chk(na > 2, !k[1]);
         chk(nb, 0);
      end
      // reserved mode parks the counter and outputs
      do_reset;
      apb(1'b1, `TW_OFF_COUNT, 32'h10);
      run(`TW_WGM_RSVD, 6'h3F, 50);
      apb(1'b0, `TW_OFF_COUNT, 32'h0);
      chk({q[15:0], 12'h0, ov, o}, 32'h0);
      print_verdict;
   end
endmodule
